/* File: verilog/rsh_pkg.sv */
// Purpose: shared constants for the reference switchover block
// Assumes: apb word registers at byte address = index * 4
// Notes:   indices are 10-bit word indices, not byte offsets
package rsh_pkg;
	// ==========================================================
	// register indices
	localparam logic [9:0] IDX_INPUT_CFG = 10'h01a;
	localparam logic [9:0] IDX_MISC_CTRL = 10'h01c;
	localparam logic [9:0] IDX_DIV_PRI   = 10'h020;
	localparam logic [9:0] IDX_DIV_SEC   = 10'h021;
	localparam logic [9:0] IDX_TIMEOUT   = 10'h022;
	localparam logic [9:0] IDX_STATUS    = 10'h023;
	localparam logic [9:0] IDX_IRQ_STAT  = 10'h024;
	localparam logic [9:0] IDX_IRQ_MASK  = 10'h025;
	localparam int         ADDR_LSB      = 2;
	localparam int         ADDR_MSB      = 11;

	// ==========================================================
	// input configuration fields
	localparam int BIT_LOOP_PD    = 0;
	localparam int BIT_PRI_SE_PD  = 1;
	localparam int BIT_SEC_SE_PD  = 2;
	localparam int BIT_PRI_CMOS   = 5;
	localparam int BIT_SEC_CMOS   = 6;

	// ==========================================================
	// misc control fields
	localparam int BIT_SEL_MANUAL = 2;
	localparam int BIT_CP_MID     = 6;
	localparam int BIT_INDEP_DIV  = 7;
	localparam int MODE_LSB       = 0;
	localparam int MODE_MSB       = 1;

	typedef enum logic [1:0] {
		RSH_MODE_REG    = 2'h0,
		RSH_MODE_PIN    = 2'h1,
		RSH_MODE_NONREV = 2'h2,
		RSH_MODE_REV    = 2'h3
	} rsh_mode_t;

	// ==========================================================
	// status and interrupt fields
	localparam int BIT_ST_PRI_OK  = 0;
	localparam int BIT_ST_SEC_OK  = 1;
	localparam int BIT_ST_ACT_SEC = 2;
	localparam int BIT_ST_HOLD    = 3;
	localparam int IRQ_W          = 5;
	localparam int IRQ_PRI_CHG    = 0;
	localparam int IRQ_SEC_CHG    = 1;
	localparam int IRQ_SWITCH     = 2;
	localparam int IRQ_HOLD_IN    = 3;
	localparam int IRQ_HOLD_OUT   = 4;

	// ==========================================================
	// widths and reset values
	localparam int          DIV_W        = 10;
	localparam int          TMO_W        = 16;
	localparam logic [9:0]  DIV_RST      = 10'h001;
	localparam logic [15:0] TIMEOUT_RST  = 16'h0400;
	localparam logic [7:0]  CFG_RST      = 8'h00;
	localparam logic [7:0]  MISC_RST     = 8'h00;

	typedef enum logic [2:0] {
		RSH_ST_PRI  = 3'b001,
		RSH_ST_SEC  = 3'b010,
		RSH_ST_HOLD = 3'b100
	} rsh_state_t;
endpackage : rsh_pkg

/* File: verilog/rsh_ref_div.sv */
// Purpose: integer divider for one reference input
// Assumes: reference sampled synchronously on pclk
// Notes:   a ratio of zero behaves as one
`timescale 1ns/100ps
module rsh_ref_div (
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire logic                     ref_in,
	input  wire logic [rsh_pkg::DIV_W-1:0] ratio,
	output logic                          div_edge,
	output logic                          div_level
);
	typedef struct packed {
		logic                      prev;
		logic [rsh_pkg::DIV_W-1:0] cnt;
		logic                      edge_o;
		logic                      level;
	} rsh_div_t;

	rsh_div_t st_reg;
	rsh_div_t st_next;

	// ==========================================================
	// edge counting
	always_comb begin
		st_next        = st_reg;
		st_next.prev   = ref_in;
		st_next.edge_o = 1'b0;
		if (ref_in && !st_reg.prev) begin
			if (st_reg.cnt + 10'h001 >= ratio) begin
				st_next.cnt    = '0;
				st_next.edge_o = 1'b1;
				st_next.level  = !st_reg.level;
			end else begin
				st_next.cnt = st_reg.cnt + 10'h001;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign div_edge  = st_reg.edge_o;
	assign div_level = st_reg.level;
endmodule : rsh_ref_div

/* File: verilog/rsh_ref_mon.sv */
// Purpose: presence monitor for one divided reference
// Assumes: div_edge is a one-cycle pulse per divided period
// Notes:   absent after reset until the first edge
`timescale 1ns/100ps
module rsh_ref_mon (
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	input  wire logic                      div_edge,
	input  wire logic [rsh_pkg::TMO_W-1:0] timeout,
	output logic                           present
);
	typedef struct packed {
		logic [rsh_pkg::TMO_W-1:0] idle;
		logic                      ok;
	} rsh_mon_t;

	rsh_mon_t st_reg;
	rsh_mon_t st_next;

	// ==========================================================
	// timeout on the oscillator clock
	always_comb begin
		st_next = st_reg;
		if (div_edge) begin
			st_next.idle = '0;
			st_next.ok   = 1'b1;
		end else if (st_reg.idle >= timeout) begin
			st_next.ok = 1'b0;
		end else begin
			st_next.idle = st_reg.idle + 16'h0001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign present = st_reg.ok;
endmodule : rsh_ref_mon

/* File: verilog/rsh_switchover.sv */
// Purpose: reference receivers, dividers, monitor, switchover, holdover
// Assumes: pclk is the oscillator-derived clock; pins synchronous
// Notes:   apb slave with one wait state on every access
//          references must stay below half the pclk rate
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/100ps
module rsh_switchover (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        primary_reference,
	input  wire logic        secondary_reference,
	input  wire logic        ref_select_pin,
	output logic             diff_rx_pd,
	output logic             pri_se_pd,
	output logic             sec_se_pd,
	output logic             active_is_secondary,
	output logic             holdover,
	output logic             cp_tristate,
	output logic             cp_midsupply,
	output logic             input_loop_resync,
	output logic             irq
);
	typedef struct packed {
		logic [7:0]                cfg;
		logic [7:0]                misc;
		logic [rsh_pkg::DIV_W-1:0] div_pri;
		logic [rsh_pkg::DIV_W-1:0] div_sec;
		logic [rsh_pkg::TMO_W-1:0] timeout;
		logic [rsh_pkg::IRQ_W-1:0] irq_stat;
		logic [rsh_pkg::IRQ_W-1:0] irq_mask;
		rsh_pkg::rsh_state_t       state;
		logic                      pri_ok_d;
		logic                      sec_ok_d;
		logic [31:0]               rdata;
		logic                      ready;
		logic                      err;
		logic                      diff_pd;
		logic                      pri_pd;
		logic                      sec_pd;
		logic                      resync;
		logic                      irq_o;
		logic                      cp_z;
		logic                      cp_mid;
		logic                      act_sec;
		logic                      hold_o;
	} rsh_top_t;

	rsh_top_t st_reg;
	rsh_top_t st_next;

	logic                      pri_seen;
	logic                      sec_seen;
	logic [1:0]                ref_seen;
	logic [1:0]                div_edge;
	logic [1:0]                ref_ok;
	logic [rsh_pkg::DIV_W-1:0] ratio [2];

	// ==========================================================
	// receiver paths
	// an input is seen as a stuck-low reference only while both diff_pd and its own single-ended pd are set
	// hazard: re-powering a high input shows one false edge
	always_comb begin
		pri_seen = primary_reference & !(st_reg.diff_pd & st_reg.pri_pd);
		sec_seen = secondary_reference & !(st_reg.diff_pd & st_reg.sec_pd);
	end

	assign ref_seen = {sec_seen, pri_seen};
	// a new ratio applies from the next input edge on
	// shared or independent ratio
	assign ratio[0] = st_reg.div_pri;
	assign ratio[1] = st_reg.misc[rsh_pkg::BIT_INDEP_DIV] ?
		st_reg.div_sec : st_reg.div_pri;

	// ==========================================================
	// dividers and monitors per input
	// both monitors share one timeout setting
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_ref
			rsh_ref_div u_div (
				.pclk      (pclk),
				.presetn   (presetn),
				.ref_in    (ref_seen[gi]),
				.ratio     (ratio[gi]),
				.div_edge  (div_edge[gi]),
				.div_level ()
			);
			rsh_ref_mon u_mon (
				.pclk     (pclk),
				.presetn  (presetn),
				.div_edge (div_edge[gi]),
				.timeout  (st_reg.timeout),
				.present  (ref_ok[gi])
			);
		end
	endgenerate

	// ==========================================================
	// next state
	logic [9:0]           idx;
	logic                 wr_go;
	logic                 rd_go;
	logic                 hit;
	logic [31:0]          rd_val;
	logic [4:0]           ev;
	rsh_pkg::rsh_mode_t   mode;
	logic                 want_sec;
	logic                 pri_ok;
	logic                 sec_ok;
	logic                 cmos_pri;
	logic                 cmos_sec;
	logic                 loop_pd;

	always_comb begin
		st_next  = st_reg;
		idx      = paddr[rsh_pkg::ADDR_MSB:rsh_pkg::ADDR_LSB];
		wr_go    = psel & penable & st_reg.ready & pwrite;
		rd_go    = psel & penable & st_reg.ready & !pwrite;
		pri_ok   = ref_ok[0];
		sec_ok   = ref_ok[1];
		mode     = rsh_pkg::rsh_mode_t'(
			st_reg.misc[rsh_pkg::MODE_MSB:rsh_pkg::MODE_LSB]);
		want_sec = 1'b0;
		ev       = '0;
		hit      = 1'b1;
		rd_val   = '0;

		// register readback
		case (idx)
			rsh_pkg::IDX_INPUT_CFG: rd_val = {24'h000000, st_reg.cfg};
			rsh_pkg::IDX_MISC_CTRL: rd_val = {24'h000000, st_reg.misc};
			rsh_pkg::IDX_DIV_PRI:   rd_val = {22'h000000, st_reg.div_pri};
			rsh_pkg::IDX_DIV_SEC:   rd_val = {22'h000000, st_reg.div_sec};
			rsh_pkg::IDX_TIMEOUT:   rd_val = {16'h0000, st_reg.timeout};
			rsh_pkg::IDX_STATUS:    rd_val = {28'h0000000,
				st_reg.state == rsh_pkg::RSH_ST_HOLD,
				st_reg.state == rsh_pkg::RSH_ST_SEC,
				st_reg.sec_ok_d, st_reg.pri_ok_d};
			rsh_pkg::IDX_IRQ_STAT:  rd_val = {27'h0000000, st_reg.irq_stat};
			rsh_pkg::IDX_IRQ_MASK:  rd_val = {27'h0000000, st_reg.irq_mask};
			default:                hit    = 1'b0;
		endcase

		// apb: one wait state, then complete
		// writes and read-clear act only at the completing edge
		st_next.ready = psel & penable & !st_reg.ready;
		// error answer stands only while ready does
		st_next.err   = 1'b0;
		if (psel && penable && !st_reg.ready) begin
			st_next.err   = !hit;
			st_next.rdata = pwrite ? 32'h00000000 : rd_val;
		end

		if (wr_go && hit) begin
			case (idx)
				rsh_pkg::IDX_INPUT_CFG: st_next.cfg     = pwdata[7:0];
				rsh_pkg::IDX_MISC_CTRL: st_next.misc    = pwdata[7:0];
				rsh_pkg::IDX_DIV_PRI:   st_next.div_pri = pwdata[9:0];
				rsh_pkg::IDX_DIV_SEC:   st_next.div_sec = pwdata[9:0];
				rsh_pkg::IDX_TIMEOUT:   st_next.timeout = pwdata[15:0];
				rsh_pkg::IDX_IRQ_MASK:  st_next.irq_mask = pwdata[4:0];
				// status words take no writes and give no error
				default:                st_next.cfg     = st_reg.cfg;
			endcase
		end

		// ======================================================
		// receiver power control
		cmos_pri = st_reg.cfg[rsh_pkg::BIT_PRI_CMOS];
		cmos_sec = st_reg.cfg[rsh_pkg::BIT_SEC_CMOS];
		loop_pd  = st_reg.cfg[rsh_pkg::BIT_LOOP_PD];
		st_next.diff_pd = loop_pd | (cmos_pri & cmos_sec);
		st_next.pri_pd = loop_pd | st_reg.cfg[rsh_pkg::BIT_PRI_SE_PD] |
			!cmos_pri;
		st_next.sec_pd = loop_pd | st_reg.cfg[rsh_pkg::BIT_SEC_SE_PD] |
			!cmos_sec;

		// ======================================================
		// switchover state machine
		// manual modes follow the choice even into an absent input
		// manual source choice
		if (mode == rsh_pkg::RSH_MODE_PIN) begin
			want_sec = ref_select_pin;
		end else begin
			want_sec = st_reg.misc[rsh_pkg::BIT_SEL_MANUAL];
		end
		st_next.resync = 1'b0;
		case (st_reg.state)
			rsh_pkg::RSH_ST_PRI: begin
				if (!pri_ok && !sec_ok) begin
					st_next.state = rsh_pkg::RSH_ST_HOLD;
				end else if (mode == rsh_pkg::RSH_MODE_REG ||
					mode == rsh_pkg::RSH_MODE_PIN) begin
					if (want_sec) begin
						st_next.state = rsh_pkg::RSH_ST_SEC;
					end
				end else if (!pri_ok && sec_ok) begin
					st_next.state = rsh_pkg::RSH_ST_SEC;
				end
			end
			rsh_pkg::RSH_ST_SEC: begin
				if (!pri_ok && !sec_ok) begin
					st_next.state = rsh_pkg::RSH_ST_HOLD;
				end else if (mode == rsh_pkg::RSH_MODE_REG ||
					mode == rsh_pkg::RSH_MODE_PIN) begin
					if (!want_sec) begin
						st_next.state = rsh_pkg::RSH_ST_PRI;
					end
				end else if (mode == rsh_pkg::RSH_MODE_REV && pri_ok) begin
					st_next.state = rsh_pkg::RSH_ST_PRI;
				end else if (!sec_ok) begin
					st_next.state = rsh_pkg::RSH_ST_PRI;
				end
			end
			rsh_pkg::RSH_ST_HOLD: begin
				// reference back, resync
				// auto mode prefers primary when both are back
				// in auto modes a lone present input wins
				if (pri_ok || sec_ok) begin
					st_next.resync = 1'b1;
					if (mode == rsh_pkg::RSH_MODE_REG ||
						mode == rsh_pkg::RSH_MODE_PIN) begin
						st_next.state = want_sec ?
							rsh_pkg::RSH_ST_SEC : rsh_pkg::RSH_ST_PRI;
					end else if (pri_ok) begin
						st_next.state = rsh_pkg::RSH_ST_PRI;
					end else begin
						st_next.state = rsh_pkg::RSH_ST_SEC;
					end
				end
			end
			default: st_next.state = rsh_pkg::RSH_ST_PRI;
		endcase

		// ======================================================
		// charge pump during holdover
		// tristate by default
		st_next.cp_z = (st_next.state == rsh_pkg::RSH_ST_HOLD) &
			!st_reg.misc[rsh_pkg::BIT_CP_MID];
		st_next.cp_mid = (st_next.state == rsh_pkg::RSH_ST_HOLD) &
			st_reg.misc[rsh_pkg::BIT_CP_MID];

		// ======================================================
		// state flags kept in flops so the outputs are glitch-free
		st_next.act_sec = st_next.state == rsh_pkg::RSH_ST_SEC;
		st_next.hold_o  = st_next.state == rsh_pkg::RSH_ST_HOLD;

		// ======================================================
		// events and sticky interrupt status
		st_next.pri_ok_d = pri_ok;
		st_next.sec_ok_d = sec_ok;
		ev[rsh_pkg::IRQ_PRI_CHG]  = pri_ok ^ st_reg.pri_ok_d;
		ev[rsh_pkg::IRQ_SEC_CHG]  = sec_ok ^ st_reg.sec_ok_d;
		ev[rsh_pkg::IRQ_SWITCH]   =
			(st_reg.state == rsh_pkg::RSH_ST_PRI &&
			 st_next.state == rsh_pkg::RSH_ST_SEC) ||
			(st_reg.state == rsh_pkg::RSH_ST_SEC &&
			 st_next.state == rsh_pkg::RSH_ST_PRI);
		ev[rsh_pkg::IRQ_HOLD_IN]  = st_reg.state != rsh_pkg::RSH_ST_HOLD &&
			st_next.state == rsh_pkg::RSH_ST_HOLD;
		ev[rsh_pkg::IRQ_HOLD_OUT] = st_next.resync;
		// read clears; a same-cycle event still sets
		// only bits the read reported are cleared, so an event
		// landing while the answer was in flight is not lost
		if (rd_go && idx == rsh_pkg::IDX_IRQ_STAT) begin
			st_next.irq_stat = ev | (st_reg.irq_stat &
				~st_reg.rdata[rsh_pkg::IRQ_W-1:0]);
		end else begin
			st_next.irq_stat = st_reg.irq_stat | ev;
		end
		// a mask change shows on irq one edge after the write
		st_next.irq_o = |(st_next.irq_stat & st_reg.irq_mask);
	end

	// ==========================================================
	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg          <= '0;
			st_reg.cfg      <= rsh_pkg::CFG_RST;
			st_reg.misc     <= rsh_pkg::MISC_RST;
			st_reg.div_pri  <= rsh_pkg::DIV_RST;
			st_reg.div_sec  <= rsh_pkg::DIV_RST;
			st_reg.timeout  <= rsh_pkg::TIMEOUT_RST;
			st_reg.state    <= rsh_pkg::RSH_ST_HOLD;
			st_reg.diff_pd  <= 1'b0;
			st_reg.pri_pd   <= 1'b1;
			st_reg.sec_pd   <= 1'b1;
			st_reg.cp_z     <= 1'b1;
			st_reg.hold_o   <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// ==========================================================
	// outputs, all straight from the state register
	assign prdata              = st_reg.rdata;
	assign pready              = st_reg.ready;
	assign pslverr             = st_reg.err;
	assign diff_rx_pd          = st_reg.diff_pd;
	assign pri_se_pd           = st_reg.pri_pd;
	assign sec_se_pd           = st_reg.sec_pd;
	assign active_is_secondary = st_reg.act_sec;
	assign holdover            = st_reg.hold_o;
	assign cp_tristate         = st_reg.cp_z;
	assign cp_midsupply        = st_reg.cp_mid;
	assign input_loop_resync   = st_reg.resync;
	assign irq                 = st_reg.irq_o;
endmodule : rsh_switchover

/* File: tb/rsh_switchover_checker.sv */
// Purpose: port-level assertions for the switchover block
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   bound to every rsh_switchover instance
`timescale 1ns/100ps
module rsh_switchover_checker (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        diff_rx_pd,
	input wire logic        pri_se_pd,
	input wire logic        sec_se_pd,
	input wire logic        active_is_secondary,
	input wire logic        holdover,
	input wire logic        cp_tristate,
	input wire logic        cp_midsupply,
	input wire logic        input_loop_resync
);
	default clocking dcb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ==========================================================
	// loop control
	chk_cp_hold: assert property (holdover |-> cp_tristate ^ cp_midsupply)
		else $error("charge pump drive wrong in holdover");
	chk_cp_idle: assert property (!holdover |-> !cp_tristate && !cp_midsupply)
		else $error("charge pump forced outside holdover");
	chk_resync_exit: assert property ($fell(holdover) |-> input_loop_resync)
		else $error("no resync on holdover exit");
	chk_resync_pulse: assert property (input_loop_resync |->
		$fell(holdover) ##1 !input_loop_resync)
		else $error("resync not a single exit pulse");
	chk_se_off: assert property (!pri_se_pd && !sec_se_pd |-> diff_rx_pd)
		else $error("differential receiver on with both buffers on");
	chk_hold_act: assert property (holdover |-> !active_is_secondary)
		else $error("secondary marked active in holdover");

	// ==========================================================
	// register bus: one wait state, one-cycle answer
	chk_apb_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
		else $error("bus answer not after one wait state");
	chk_ready_idle: assert property (!(psel && penable) |-> !pready)
		else $error("ready outside an access");
	chk_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error answer malformed");
endmodule : rsh_switchover_checker

bind rsh_switchover rsh_switchover_checker chk_u (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.diff_rx_pd(diff_rx_pd), .pri_se_pd(pri_se_pd), .sec_se_pd(sec_se_pd),
	.active_is_secondary(active_is_secondary), .holdover(holdover),
	.cp_tristate(cp_tristate), .cp_midsupply(cp_midsupply),
	.input_loop_resync(input_loop_resync)
);

/* File: tb/rsh_ref_src.sv */
// Purpose: external reference clock source that can be lost
// Assumes: period is a whole number of bench clock cycles
// Notes:   a lost source stops and holds its last level
`timescale 1ns/100ps
module rsh_ref_src #(
	parameter int HALF = 2
) (
	input  wire logic pclk,
	input  wire logic enable,
	output logic      ref_out
);
	int   cnt = 0;
	logic lvl = 1'b0;

	assign ref_out = lvl;

	// a failed source stops toggling rather than floating
	always @(posedge pclk) begin
		if (enable) begin
			cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
			if (cnt == HALF - 1)
				lvl <= ~lvl;
		end
	end
endmodule : rsh_ref_src

/* File: tb/tb_top.sv */
// Purpose: self-checking bench for the switchover block
// Assumes: absence timeout reprogrammed short to 16 cycles
// Notes:   settle waits exceed timeout plus slowest period
`timescale 1ns/100ps
module tb_top;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready, pslverr, pri_ref, sec_ref, diff_rx_pd;
	logic        pri_se_pd, sec_se_pd, active_is_secondary, holdover;
	logic        cp_tristate, cp_midsupply, input_loop_resync, irq;
	logic        pri_en = 1'b0;
	logic        sec_en = 1'b0;
	logic        ref_select_pin = 1'b0;
	int          bad_count = 0;
	int          check_count = 0;
	int          cycles = 0;

	always #10 pclk = ~pclk;

	rsh_ref_src #(.HALF(2)) pri_src_u (.pclk(pclk), .enable(pri_en),
		.ref_out(pri_ref));
	rsh_ref_src #(.HALF(3)) sec_src_u (.pclk(pclk), .enable(sec_en),
		.ref_out(sec_ref));
	rsh_switchover dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .primary_reference(pri_ref),
		.secondary_reference(sec_ref), .ref_select_pin(ref_select_pin),
		.diff_rx_pd(diff_rx_pd), .pri_se_pd(pri_se_pd),
		.sec_se_pd(sec_se_pd), .active_is_secondary(active_is_secondary),
		.holdover(holdover), .cp_tristate(cp_tristate),
		.cp_midsupply(cp_midsupply), .input_loop_resync(input_loop_resync),
		.irq(irq));

	// ==========================================================
	// shared tasks
	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : conclude

	// hang guard: run needs well under 3000 cycles
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			bad_count++;
			conclude();
		end
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask : cyc

	task automatic chk(input string w, input logic [31:0] e,
		input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", w, e, g);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [9:0] idx,
		input logic [31:0] wd, output logic [31:0] rd, output logic err);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic wr(input logic [9:0] idx, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, idx, d, r, e);
	endtask : wr

	task automatic rdc(input string w, input logic [9:0] idx,
		input logic [31:0] exp);
		logic [31:0] r;
		logic        e;
		apb(1'b0, idx, 32'h0, r, e);
		chk(w, exp, r);
	endtask : rdc

	// status word: b0 pri ok, b1 sec ok, b2 active sec, b3 holdover
	task automatic stchk(input string w, input logic [31:0] st);
		rdc(w, rsh_pkg::IDX_STATUS, st);
		chk(w, {30'h0, st[3:2]}, {30'h0, holdover, active_is_secondary});
	endtask : stchk

	// ==========================================================
	// scenarios
	task automatic t_reset();
		logic [31:0] r;
		logic        e;
		rdc("cfg", rsh_pkg::IDX_INPUT_CFG, 32'(rsh_pkg::CFG_RST));
		rdc("misc", rsh_pkg::IDX_MISC_CTRL, 32'(rsh_pkg::MISC_RST));
		rdc("div pri", rsh_pkg::IDX_DIV_PRI, 32'(rsh_pkg::DIV_RST));
		rdc("div sec", rsh_pkg::IDX_DIV_SEC, 32'(rsh_pkg::DIV_RST));
		rdc("timeout", rsh_pkg::IDX_TIMEOUT, 32'(rsh_pkg::TIMEOUT_RST));
		rdc("mask", rsh_pkg::IDX_IRQ_MASK, 32'h0);
		wr(rsh_pkg::IDX_STATUS, 32'h7);
		stchk("status ro", 32'h8);
		chk("tristate", 32'h1, {31'h0, cp_tristate});
		apb(1'b0, 10'h030, 32'h0, r, e);
		chk("unmapped err", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, r);
		$display("t_reset done");
	endtask : t_reset

	task automatic t_power();
		logic [7:0] cfg [6] = '{8'h00, 8'h20, 8'h60, 8'h62, 8'h64, 8'h61};
		logic [2:0] exp [6] = '{3'h3, 3'h1, 3'h4, 3'h6, 3'h5, 3'h7};
		for (int i = 0; i < 6; i++) begin
			wr(rsh_pkg::IDX_INPUT_CFG, {24'h0, cfg[i]});
			cyc(2);
			chk("power", {29'h0, exp[i]},
				{29'h0, diff_rx_pd, pri_se_pd, sec_se_pd});
		end
		wr(rsh_pkg::IDX_INPUT_CFG, 32'h0);
		$display("t_power done");
	endtask : t_power

	task automatic t_auto();
		wr(rsh_pkg::IDX_TIMEOUT, 32'd16);
		wr(rsh_pkg::IDX_MISC_CTRL, 32'h2);
		pri_en <= 1'b1;
		sec_en <= 1'b1;
		cyc(40);
		stchk("both up", 32'h3);
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(rsh_pkg::IDX_IRQ_MASK, 32'h1f);
		// irq follows the new mask one edge later
		cyc(1);
		chk("irq raised", 32'h1, {31'h0, irq});
		rdc("irq stat", rsh_pkg::IDX_IRQ_STAT, 32'h13);
		chk("irq cleared", 32'h0, {31'h0, irq});
		pri_en <= 1'b0;
		cyc(40);
		stchk("pri lost", 32'h6);
		pri_en <= 1'b1;
		cyc(40);
		stchk("pri back", 32'h7);
		sec_en <= 1'b0;
		cyc(40);
		stchk("sec lost", 32'h1);
		pri_en <= 1'b0;
		cyc(40);
		stchk("both lost", 32'h8);
		chk("tristate", 32'h1, {31'h0, cp_tristate});
		sec_en <= 1'b1;
		cyc(40);
		stchk("sec only", 32'h6);
		$display("t_auto done");
	endtask : t_auto

	task automatic t_revert();
		wr(rsh_pkg::IDX_MISC_CTRL, 32'h3);
		pri_en <= 1'b1;
		cyc(40);
		stchk("revert", 32'h3);
		pri_en <= 1'b0;
		cyc(40);
		stchk("rev lost", 32'h6);
		pri_en <= 1'b1;
		cyc(40);
		stchk("revert again", 32'h3);
		$display("t_revert done");
	endtask : t_revert

	task automatic t_mid();
		logic [31:0] n;
		wr(rsh_pkg::IDX_MISC_CTRL, 32'h43);
		pri_en <= 1'b0;
		sec_en <= 1'b0;
		cyc(40);
		chk("mid hold", 32'h1, {31'h0, holdover});
		chk("mid drive", 32'h2, {30'h0, cp_midsupply, cp_tristate});
		pri_en <= 1'b1;
		n = 32'h0;
		repeat (40) begin
			@(posedge pclk);
			n = n + {31'h0, input_loop_resync};
		end
		chk("resync count", 32'h1, n);
		$display("t_mid done");
	endtask : t_mid

	task automatic t_manual();
		sec_en <= 1'b1;
		wr(rsh_pkg::IDX_MISC_CTRL, 32'h4);
		cyc(4);
		chk("reg sel sec", 32'h1, {31'h0, active_is_secondary});
		wr(rsh_pkg::IDX_MISC_CTRL, 32'h0);
		cyc(4);
		chk("reg sel pri", 32'h0, {31'h0, active_is_secondary});
		wr(rsh_pkg::IDX_MISC_CTRL, 32'h1);
		ref_select_pin <= 1'b1;
		cyc(4);
		chk("pin sel sec", 32'h1, {31'h0, active_is_secondary});
		ref_select_pin <= 1'b0;
		cyc(4);
		chk("pin sel pri", 32'h0, {31'h0, active_is_secondary});
		$display("t_manual done");
	endtask : t_manual

	// reg-manual on primary; refs 4 and 6 cycles, timeout 16
	task automatic t_div();
		wr(rsh_pkg::IDX_MISC_CTRL, 32'h0);
		wr(rsh_pkg::IDX_DIV_PRI, 32'd1023);
		cyc(60);
		stchk("shared 1023", 32'h8);
		wr(rsh_pkg::IDX_MISC_CTRL, 32'h80);
		cyc(60);
		stchk("independent", 32'h2);
		wr(rsh_pkg::IDX_DIV_PRI, 32'd3);
		cyc(60);
		stchk("ratio 3", 32'h3);
		$display("t_div done");
	endtask : t_div

	initial begin
		cyc(4);
		presetn <= 1'b1;
		cyc(1);
		t_reset();
		t_power();
		t_auto();
		t_revert();
		t_mid();
		t_manual();
		t_div();
		conclude();
	end
endmodule : tb_top
